// ==== pkg/ssp_baud_if.sv ====
// Purpose: link between top and baud divider
// Assumes: single clock domain mclk
// Notes: tick marks one half serial-clock period
`timescale 1ns/100ps
`default_nettype none
interface ssp_baud_if;
  logic run;
  logic [15:0] divisor;
  logic tick;
  modport prov (input run, input divisor, output tick);
  modport user (output run, output divisor, input tick);
endinterface
`default_nettype wire

// ==== pkg/ssp_defs.svh ====
// Purpose: constants of the SPI serial unit
// Assumes: included by the package and the top module
// Notes: offsets are APB byte addresses
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
// ****************************************
// Register offsets
// ****************************************
`define SSP_OFS_CTRL 8'h00
`define SSP_OFS_MODE 8'h04
`define SSP_OFS_FLAGS 8'h08
`define SSP_OFS_EXT 8'h0C
`define SSP_OFS_DATA 8'h10
`define SSP_OFS_BAUD 8'h14
`define SSP_OFS_FCNT 8'h18
`define SSP_OFS_ISTAT 8'h1C
`define SSP_OFS_IMASK 8'h20
// ****************************************
// Field positions and codes
// ****************************************
`define SSP_CTRL_PCLR 7
`define SSP_FLAGS_ECLR 7
`define SSP_MODE_SPI 3'h2
`define SSP_LEN_5 3'h1
`define SSP_LEN_6 3'h2
`define SSP_LEN_7 3'h3
`define SSP_LEN_9 3'h4
`define SSP_IRQ_RX 0
`define SSP_IRQ_TX 1
`define SSP_IRQ_IDLE 2
`define SSP_IRQ_OVR 3
// ****************************************
// Reset values
// ****************************************
`define SSP_RST_TX_EMPTY 1'h1
`define SSP_RST_SCK 1'h1
`define SSP_RST_PIN_SYNC 3'h7
`endif

// ==== pkg/ssp_pkg.sv ====
// Purpose: types shared by the SPI serial unit
// Assumes: ssp_defs.svh on the include path
// Notes: register layouts are packed structs
package ssp_pkg;
  `include "ssp_defs.svh"

  // Control register layout, bit 7 first
  typedef struct packed {
    logic programmable_clear;
    logic role_select;
    logic spi_select;
    logic rx_irq_enable;
    logic tx_irq_enable;
    logic tx_bus_idle_irq_enable;
    logic rx_enable;
    logic tx_enable;
  } ssp_ctrl_t;

  typedef struct packed {
    logic [2:0] operating_mode_field;
    logic wakeup_control;
    logic clock_invert;
    logic bit_direction_select;
    logic clock_output_enable;
    logic data_output_enable;
  } ssp_mode_t;

  typedef struct packed {
    logic output_pin_set;
    logic [1:0] rsvd;
    logic [1:0] frame_wait_field;
    logic [2:0] frame_length_field;
  } ssp_ext_t;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_WAIT} ssp_fsm_t;

  // Frame length in bits from the length field
  function automatic logic [3:0] ssp_len(input logic [2:0] c);
    unique case (c)
      `SSP_LEN_5: ssp_len = 4'h5;
      `SSP_LEN_6: ssp_len = 4'h6;
      `SSP_LEN_7: ssp_len = 4'h7;
      `SSP_LEN_9: ssp_len = 4'h9;
      default: ssp_len = 4'h8;
    endcase
  endfunction
endpackage

// ==== rtl/ssp_baud.sv ====
// Purpose: half-period enable for the generated clock
// Assumes: divisor stable while run is high
// Notes: first tick comes divisor+1 cycles after run rises
`timescale 1ns/100ps
`default_nettype none
module ssp_baud import ssp_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Divider link
  ssp_baud_if.prov bif
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } ssp_baud_st_t;

  ssp_baud_st_t r;
  ssp_baud_st_t n;

  // Count restarts whenever the engine idles
  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (!bif.run) begin
      n.cnt = 16'h0000;
    end else if (r.cnt == bif.divisor) begin
      n.cnt = 16'h0000;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bif.tick = r.tick;
endmodule // ssp_baud
`default_nettype wire

// ==== rtl/ssp_spi_top.sv ====
// Purpose: serial unit in SPI mode, clock idles high
// Assumes: APB master on mclk, serial pins asynchronous
// Notes: every APB access takes one wait state
// Operation
// - Master needs role 0, clock out 1; slave role 1, clock out 0.
// - Master data write clears empty flag, drives bit one, shifts on rises.
// - Master sets empty flag half a clock before first fall.
// - Empty flag with transmit interrupt enable raises transmit interrupt; next word may follow.
// - Master reception samples data on falling edges of generated clock.
// - Last received bit sets full flag, may interrupt, word readable.
// - Reading received word clears the full flag.
// - Frame count makes master clock exactly that many frames.
// - Full duplex shifts out on rises and samples on falls.
// - Nonzero wait field inserts idle time between master frames.
// - Slave data write clears empty flag, bit one driven, flag returns.
// - Slave reception samples on falling edges of peer clock.
// - Switch to transmit; written word shifts after reception ends.
`timescale 1ns/100ps
`default_nettype none
`include "ssp_defs.svh"
module ssp_spi_top import ssp_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe,
  // Interrupt
  output logic irq
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ssp_ctrl_t ctrl;
    ssp_mode_t mode;
    ssp_ext_t ext;
    logic [15:0] baud;
    logic [7:0] fcnt;
    logic [8:0] tx_buf;
    logic [8:0] rx_word;
    logic tx_empty;
    logic rx_full;
    logic overrun;
    logic [3:0] ist;
    logic [3:0] imask;
    ssp_fsm_t st;
    logic [8:0] sh;
    logic [8:0] rsh;
    logic [3:0] bitcnt;
    logic last;
    logic [2:0] wcnt;
    logic sck_o;
    logic sck_oe;
    logic dout;
    logic dout_oe;
    logic [2:0] sck_s;
    logic [1:0] din_s;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ssp_regs_t;

  ssp_regs_t r;
  ssp_regs_t n;

  logic [3:0] len;
  logic [8:0] lmask;
  logic mode_ok;
  logic master;
  logic slave;
  logic sck_fall;
  logic sck_rise;
  logic fall_ev;
  logic rise_ev;
  logic acc;
  logic wr;
  logic rd;
  logic pend;
  logic start;
  logic rxs;
  logic rx_done;
  logic [3:0] bc;
  logic hit;
  logic [31:0] rdata;
  logic [8:0] rsh_n;
  logic [8:0] sh_n;
  logic [3:0] w1c;
  logic [3:0] iset;

  ssp_baud_if bif();

  ssp_baud u_baud (
    .mclk(mclk),
    .resetn(resetn),
    .bif(bif)
  );

  // Divider runs only while a master frame or wait is in progress
  assign bif.run = master & (r.st != ST_IDLE);
  assign bif.divisor = r.baud;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    n = r;
    len = ssp_len(r.ext.frame_length_field);
    lmask = 9'h1FF >> (4'h9 - len);
    mode_ok = (r.mode.operating_mode_field == `SSP_MODE_SPI) & r.ctrl.spi_select
      & !r.mode.clock_invert;
    master = mode_ok & !r.ctrl.role_select & r.mode.clock_output_enable;
    slave = mode_ok & r.ctrl.role_select & !r.mode.clock_output_enable;
    // Edges only from the second synchroniser stage onward
    sck_fall = r.sck_s[2] & !r.sck_s[1];
    sck_rise = !r.sck_s[2] & r.sck_s[1];
    fall_ev = master ? (bif.tick & r.sck_o) : (slave & sck_fall);
    rise_ev = master ? (bif.tick & !r.sck_o) : (slave & sck_rise);
    acc = psel & penable;
    wr = acc & pwrite & r.pready;
    rd = acc & !pwrite & r.pready;
    // counted frames keep the master clocking
    pend = r.ctrl.tx_enable & (!r.tx_empty | (r.fcnt != 8'h00));
    start = 1'b0;
    rxs = 1'b0;
    rx_done = 1'b0;
    rsh_n = r.rsh;
    sh_n = r.bitcnt == 4'h0 ? r.sh : r.sh;
    n.sck_s = {r.sck_s[1:0], sck_in};
    n.din_s = {r.din_s[0], sdata_in};

    // Frame sequencer
    unique case (r.st)
      ST_IDLE: begin
        n.sck_o = 1'b1;
        // master clocks only with a written word or counted frames pending
        if (master & pend) begin
          start = 1'b1;
        // slave load assumes clock idle high
        end else if (slave & r.ctrl.tx_enable & !r.tx_empty) begin
          start = 1'b1;
        end else if (slave & sck_fall & r.ctrl.rx_enable) begin
          rxs = 1'b1;
          n.st = ST_SHIFT;
          n.bitcnt = 4'h0;
        end
      end
      ST_SHIFT: begin
        if (rise_ev) begin
          if (master) begin
            n.sck_o = 1'b1;
          end
          if (r.last) begin
            n.last = 1'b0;
            if (pend & (r.ext.frame_wait_field != 2'h0)) begin
              n.st = ST_WAIT;
              n.wcnt = {r.ext.frame_wait_field, 1'b0};
            end else begin
              n.st = ST_IDLE;
            end
          end else begin
            sh_n = r.mode.bit_direction_select ? {r.sh[7:0], 1'b0} : {1'b0, r.sh[8:1]};
            n.sh = sh_n;
            n.dout = r.mode.bit_direction_select ? sh_n[len - 4'h1] : sh_n[0];
          end
        end
      end
      ST_WAIT: begin
        if (bif.tick) begin
          n.wcnt = r.wcnt - 3'h1;
          if (r.wcnt == 3'h1) begin
            n.st = ST_IDLE;
          end
        end
      end
    endcase

    // A frame opened by this very fall counts from zero, not from the stale count
    bc = rxs ? 4'h0 : r.bitcnt;
    if (((r.st == ST_SHIFT) | rxs) & fall_ev) begin
      if (master) begin
        n.sck_o = 1'b0;
      end
      if (r.mode.bit_direction_select) begin
        rsh_n = {r.rsh[7:0], r.din_s[1]};
      end else begin
        rsh_n = r.rsh >> 1;
        rsh_n[len - 4'h1] = r.din_s[1];
      end
      n.rsh = rsh_n;
      if (bc == len - 4'h1) begin
        rx_done = r.ctrl.rx_enable;
        n.last = master;
        if (slave) begin
          n.st = ST_IDLE;
        end
      end else begin
        n.bitcnt = bc + 4'h1;
      end
    end

    if (start) begin
      n.sh = r.tx_buf;
      n.dout = r.mode.bit_direction_select ? r.tx_buf[len - 4'h1] : r.tx_buf[0];
      // empty again as the frame opens
      // slave flag returns with bit one
      n.tx_empty = 1'b1;
      n.st = ST_SHIFT;
      n.bitcnt = 4'h0;
      n.last = 1'b0;
      n.rsh = 9'h000;
      if (master & (r.fcnt != 8'h00)) begin
        n.fcnt = r.fcnt - 8'h01;
      end
    end

    // Leaving the mode aborts any frame
    if (!(master | slave)) begin
      n.st = ST_IDLE;
      n.sck_o = 1'b1;
    end

    // Register writes take effect as pready is sampled
    if (wr) begin
      case (paddr)
        `SSP_OFS_CTRL: begin
          n.ctrl = pwdata[7:0];
          n.ctrl.programmable_clear = 1'b0;
          if (pwdata[`SSP_CTRL_PCLR]) begin
            n.st = ST_IDLE;
            n.sck_o = 1'b1;
            n.last = 1'b0;
            n.tx_empty = 1'b1;
          end
        end
        `SSP_OFS_MODE: n.mode = pwdata[7:0];
        `SSP_OFS_FLAGS: begin
          if (pwdata[`SSP_FLAGS_ECLR]) begin
            n.overrun = 1'b0;
          end
        end
        `SSP_OFS_EXT: n.ext = pwdata[7:0];
        `SSP_OFS_DATA: begin
          // new word waits for reception end
          n.tx_buf = pwdata[8:0];
          n.tx_empty = 1'b0;
        end
        `SSP_OFS_BAUD: n.baud = pwdata[15:0];
        `SSP_OFS_FCNT: n.fcnt = pwdata[7:0];
        `SSP_OFS_IMASK: n.imask = pwdata[3:0];
        default: n.ctrl = n.ctrl;
      endcase
    end

    if (rd & (paddr == `SSP_OFS_DATA)) begin
      n.rx_full = 1'b0;
    end
    // set wins over the read clear
    if (rx_done) begin
      n.rx_word = rsh_n & lmask;
      n.rx_full = 1'b1;
      if (r.rx_full & !(rd & (paddr == `SSP_OFS_DATA))) begin
        n.overrun = 1'b1;
      end
    end

    // interrupt sources, sticky with set over clear
    iset = 4'h0;
    iset[`SSP_IRQ_RX] = r.rx_full & r.ctrl.rx_irq_enable;
    iset[`SSP_IRQ_TX] = r.tx_empty & r.ctrl.tx_irq_enable;
    iset[`SSP_IRQ_IDLE] = r.tx_empty & (r.st == ST_IDLE) & r.ctrl.tx_bus_idle_irq_enable;
    iset[`SSP_IRQ_OVR] = r.overrun;
    w1c = (wr & (paddr == `SSP_OFS_ISTAT)) ? pwdata[3:0] : 4'h0;
    n.ist = (r.ist & ~w1c) | iset;
    n.irq = |(n.ist & n.imask);

    // Pin enables follow the registered mode
    n.sck_oe = master;
    n.dout_oe = (master | slave) & r.mode.data_output_enable & r.ctrl.tx_enable;

    // Read mux; unmapped addresses answer with an error
    hit = 1'b1;
    case (paddr)
      `SSP_OFS_CTRL: rdata = {24'h000000, r.ctrl};
      `SSP_OFS_MODE: rdata = {24'h000000, r.mode};
      `SSP_OFS_FLAGS: rdata = {28'h0000000, r.overrun, r.rx_full, r.tx_empty,
        r.tx_empty & (r.st == ST_IDLE)};
      `SSP_OFS_EXT: rdata = {24'h000000, r.ext};
      `SSP_OFS_DATA: rdata = {23'h000000, r.rx_word};
      `SSP_OFS_BAUD: rdata = {16'h0000, r.baud};
      `SSP_OFS_FCNT: rdata = {24'h000000, r.fcnt};
      `SSP_OFS_ISTAT: rdata = {28'h0000000, r.ist};
      `SSP_OFS_IMASK: rdata = {28'h0000000, r.imask};
      default: begin
        rdata = 32'h00000000;
        hit = 1'b0;
      end
    endcase
    n.pready = acc & !r.pready;
    if (acc & !r.pready) begin
      n.prdata = rdata;
      n.pslverr = !hit;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.tx_empty <= `SSP_RST_TX_EMPTY;
      r.sck_o <= `SSP_RST_SCK;
      r.sck_s <= `SSP_RST_PIN_SYNC;
    end else begin
      r <= n;
    end
  end

  // Ports come straight from the state register
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign sck_out = r.sck_o;
  assign sck_oe = r.sck_oe;
  assign sdata_out = r.dout;
  assign sdata_oe = r.dout_oe;
  assign irq = r.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_ROLE: assert property (r.sck_oe |-> ($past(r.mode.clock_output_enable)
    && !$past(r.ctrl.role_select))) else $error("clock driven outside master role");
  AST_TXWR: assert property ((wr && paddr == `SSP_OFS_DATA) |=> !r.tx_empty)
    else $error("data write left empty flag set");
  AST_TXSET: assert property ((start && master) |=> (r.tx_empty && r.sck_o
    && r.st == ST_SHIFT)) else $error("master frame start wrong");
  AST_TXIRQ: assert property ((r.tx_empty && r.ctrl.tx_irq_enable
    && r.imask[`SSP_IRQ_TX]) |=> irq) else $error("transmit interrupt missing");
  AST_RXFULL: assert property (rx_done |=> (r.rx_full
    && r.rx_word == $past(rsh_n & lmask))) else $error("received word not posted");
  AST_RDCLR: assert property ((rd && paddr == `SSP_OFS_DATA && !rx_done)
    |=> !r.rx_full) else $error("read did not clear full flag");
  AST_FCNT: assert property (((r.fcnt != $past(r.fcnt)) && !$past(wr))
    |-> r.fcnt == $past(r.fcnt) - 8'h01) else $error("frame count moved wrongly");
  AST_WAIT: assert property ($rose(r.st == ST_WAIT)
    |-> $past(r.ext.frame_wait_field) != 2'h0) else $error("wait without wait field");
  AST_SLVTX: assert property ((start && slave) |=> (r.tx_empty
    && r.dout == $past(r.mode.bit_direction_select ? r.tx_buf[len - 4'h1] : r.tx_buf[0])))
    else $error("slave first bit wrong");
  AST_IDLEHI: assert property ((master && r.st != ST_SHIFT) |-> sck_out)
    else $error("generated clock low outside frame");
endmodule // ssp_spi_top
`default_nettype wire

// ==== verif/ssp_peer.sv ====
// Purpose: serial peer on the far side of the unit
// Assumes: unit clock idles high, MSB first on the wire
// Notes: driven line shows the inverse of its last bit when released
`timescale 1ns/100ps
`default_nettype none
module ssp_peer (
  // Unit side
  input wire logic dut_sck,
  input wire logic dut_sck_oe,
  input wire logic dut_sdo,
  // Peer side
  output logic sck,
  output logic sdo
);
  logic [8:0] tx_sr;
  logic [8:0] rx_sr;
  int len;
  int bit_i;

  // Idle: clock high, data low
  initial begin
    sck = 1'b1;
    sdo = 1'b0;
    tx_sr = '0;
    rx_sr = '0;
    len = 8;
    bit_i = 0;
  end

  // Load a word; first bit must be on the line before the first fall
  task automatic arm(input logic [8:0] w, input int n);
    len = n;
    tx_sr = w;
    rx_sr = '0;
    bit_i = 0;
    sdo = w[n-1];
  endtask

  task automatic step;
    bit_i++;
    sdo = (bit_i < len) ? tx_sr[len-1-bit_i] : ~sdo;
  endtask

  // sample on falls, shift on rises while the unit clocks
  always @(negedge dut_sck) if (dut_sck_oe) rx_sr = {rx_sr[7:0], dut_sdo};
  always @(posedge dut_sck) if (dut_sck_oe) step();

  // peer clock only for a slave unit
  // clock stands high outside the frame
  task automatic frame(input logic [8:0] w, input int n);
    arm(w, n);
    #37;
    repeat (n) begin
      sck = 1'b0;
      rx_sr = {rx_sr[7:0], dut_sdo};
      #80;
      sck = 1'b1;
      step();
      #80;
    end
  endtask
endmodule // ssp_peer
`default_nettype wire

// ==== verif/test_sync_serial_spi_mode_one.sv ====
// Purpose: self-checking bench of the SPI serial unit
// Assumes: APB master here, serial peer model on the pins
// Notes: MSB first; random words and divisors from a fixed seed
`timescale 1ns/100ps
`default_nettype none
`include "ssp_defs.svh"
module test_sync_serial_spi_mode_one import ssp_pkg::*;;
  logic mclk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sck_in, sck_out, sck_oe, sdata_out, sdata_oe, irq, peer_sck, peer_sdo;
  logic sck_q = 1'b1;
  int error_cnt = 0;
  int n_tests = 0;
  int falls = 0;
  int hi_cnt = 0;
  int cyc = 0;
  int spans[$];

  // Clock pin level: the unit drives it only as master
  assign sck_in = sck_oe ? sck_out : peer_sck;

  ssp_spi_top i_ssp_spi_top (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .sdata_in(peer_sdo), .sdata_out(sdata_out), .sdata_oe(sdata_oe), .irq(irq));

  ssp_peer i_ssp_peer (.dut_sck(sck_out), .dut_sck_oe(sck_oe), .dut_sdo(sdata_out),
    .sck(peer_sck), .sdo(peer_sdo));

  // ****************************************
  // Clock, monitor and tasks
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Falls and high spans of the generated clock; hang guard
  always @(posedge mclk) begin
    sck_q <= sck_out;
    hi_cnt <= sck_out ? hi_cnt + 1 : 0;
    if (sck_q && !sck_out) begin
      falls <= falls + 1;
      spans.push_back(hi_cnt);
    end
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      $display("[ERR] %0t run timed out", $time);
      complete_run();
    end
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the run's own timeout ends this wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  // Frame length from the length code
  function automatic int exp_len(input logic [2:0] c);
    case (c)
      3'h1: return 5;
      3'h2: return 6;
      3'h3: return 7;
      3'h4: return 9;
      default: return 8;
    endcase
  endfunction

  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 3000) begin
      @(posedge mclk);
      k++;
    end
    chk(32'(irq), 32'h1, "interrupt raised");
  endtask

  // Master frame; always receives, sends only when the output is on
  task automatic master_xfer(input logic [2:0] lc, input logic doe);
    logic [8:0] dw;
    logic [8:0] pw;
    logic [31:0] q;
    logic [31:0] m;
    int n;
    int f0;
    dw = 9'($urandom);
    pw = 9'($urandom);
    n = exp_len(lc);
    m = (32'h1 << n) - 32'h1;
    // Two input synchroniser stages need a half period of three cycles or more
    wr(`SSP_OFS_BAUD, 32'($urandom_range(5, 2)));
    wr(`SSP_OFS_EXT, {29'h0, lc});
    wr(`SSP_OFS_MODE, {24'h0, 7'h23, doe});
    i_ssp_peer.arm(pw, n);
    f0 = falls;
    wr(`SSP_OFS_DATA, 32'(dw));
    wait_irq();
    chk(32'(falls - f0), 32'(n), "clock falls per frame");
    wr(`SSP_OFS_IMASK, 32'h0);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0, "masked irq");
    wr(`SSP_OFS_IMASK, 32'h1);
    rd(`SSP_OFS_DATA, q);
    chk(q, 32'(pw) & m, "word received");
    if (doe) chk(32'(i_ssp_peer.rx_sr) & m, 32'(dw) & m, "word sent");
    else chk(32'(sdata_oe), 32'h0, "output off");
    rd(`SSP_OFS_FLAGS, q);
    chk(q & 32'h4, 32'h0, "full flag cleared");
    wr(`SSP_OFS_ISTAT, 32'h1);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0, "irq cleared");
    chk(32'(sck_out), 32'h1, "clock idles high");
  endtask

  // Slave frame clocked by the peer
  task automatic slave_xfer;
    logic [8:0] dw;
    logic [8:0] pw;
    logic [31:0] q;
    dw = 9'($urandom);
    pw = 9'($urandom);
    wr(`SSP_OFS_DATA, 32'(dw));
    rd(`SSP_OFS_FLAGS, q);
    chk(q & 32'h2, 32'h2, "empty back after bit one");
    i_ssp_peer.frame(pw, 8);
    repeat (8) @(posedge mclk);
    rd(`SSP_OFS_FLAGS, q);
    chk(q & 32'h4, 32'h4, "full after frame");
    rd(`SSP_OFS_DATA, q);
    chk(q, 32'(pw[7:0]), "slave word received");
    chk(32'(i_ssp_peer.rx_sr[7:0]), 32'(dw[7:0]), "slave word sent");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] q;
    logic e;
    int f0;
    int s0;
    int hi;
    int k;
    logic [8:0] pw;
    logic [8:0] dw;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'hA66E));
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    rd(`SSP_OFS_FLAGS, q);
    chk(q & 32'h6, 32'h2, "flags after reset");
    apb(1'b0, 8'h24, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1, "unmapped access");
    $display("test reset done");
    wr(`SSP_OFS_IMASK, 32'h1);
    wr(`SSP_OFS_CTRL, 32'h33);
    for (int i = 0; i < 5; i++) master_xfer(3'(i), (i == 2) ? 1'b0 : 1'b1);
    chk(32'(sck_oe), 32'h1, "master drives clock");
    $display("test master frames done");
    // Two counted frames under each wait code
    wr(`SSP_OFS_CTRL, 32'h21);
    wr(`SSP_OFS_BAUD, 32'h1);
    for (int w = 0; w < 4; w++) begin
      wr(`SSP_OFS_EXT, 32'(w << 3));
      f0 = falls;
      s0 = spans.size();
      wr(`SSP_OFS_FCNT, 32'h2);
      k = 0;
      while (falls - f0 < 16 && k < 500) begin
        @(posedge mclk);
        k++;
      end
      repeat (40) @(posedge mclk);
      hi = 0;
      for (int j = s0 + 1; j < spans.size(); j++) if (spans[j] > hi) hi = spans[j];
      chk(32'(falls - f0), 32'd16, "frames from count");
      if (w == 0) chk(32'(hi <= 4), 32'h1, "no gap");
      else chk(32'(hi >= 4 * w + 2), 32'h1, "gap between frames");
    end
    $display("test frame count and wait done");
    wr(`SSP_OFS_IMASK, 32'h2);
    wr(`SSP_OFS_CTRL, 32'h29);
    repeat (3) @(posedge mclk);
    chk(32'(irq), 32'h1, "tx empty irq");
    wr(`SSP_OFS_CTRL, 32'h21);
    wr(`SSP_OFS_ISTAT, 32'hF);
    repeat (3) @(posedge mclk);
    chk(32'(irq), 32'h0, "tx irq cleared");
    $display("test tx irq done");
    wr(`SSP_OFS_CTRL, 32'h63);
    wr(`SSP_OFS_MODE, 32'h45);
    wr(`SSP_OFS_EXT, 32'h0);
    repeat (2) @(posedge mclk);
    chk(32'(sck_oe), 32'h0, "slave leaves clock");
    repeat (3) slave_xfer();
    $display("test slave frames done");
    // Receive-then-send: output off, receive interrupt on, dummy words while clock is high
    wr(`SSP_OFS_MODE, 32'h44);
    wr(`SSP_OFS_CTRL, 32'h73);
    wr(`SSP_OFS_IMASK, 32'h1);
    for (int i = 0; i < 3; i++) begin
      // Third frame has no dummy word and opens on the first clock fall
      if (i < 2) wr(`SSP_OFS_DATA, 32'h0);
      pw = 9'($urandom);
      i_ssp_peer.frame(pw, 8);
      wait_irq();
      rd(`SSP_OFS_DATA, q);
      chk(q, 32'(pw[7:0]), "continuous slave word");
      wr(`SSP_OFS_ISTAT, 32'h1);
    end
    // Switch to sending once reception has ended
    wr(`SSP_OFS_MODE, 32'h45);
    wr(`SSP_OFS_CTRL, 32'h61);
    dw = 9'($urandom);
    wr(`SSP_OFS_DATA, 32'(dw));
    i_ssp_peer.frame(9'($urandom), 8);
    chk(32'(i_ssp_peer.rx_sr[7:0]), 32'(dw[7:0]), "word sent after switch");
    $display("test receive then send done");
    // Invalid mode settings must not clock
    wr(`SSP_OFS_CTRL, 32'h21);
    foreach (q[i]) if (i < 2) begin
      wr(`SSP_OFS_MODE, (i == 0) ? 32'h4F : 32'h07);
      f0 = falls;
      wr(`SSP_OFS_DATA, 32'($urandom));
      repeat (60) @(posedge mclk);
      chk(32'(falls - f0), 32'h0, "refused mode");
    end
    $display("test refused modes done");
    complete_run();
  end
endmodule // test_sync_serial_spi_mode_one
`default_nettype wire
